/* File: src/bsm_pkg.sv */
// shared constants and types of the boundary-scan data path
package bsm_pkg;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  localparam int         IR_W                        = 10;
  localparam logic [9:0] IR_IDCODE                   = 10'h006;
  localparam logic [9:0] IR_USERCODE                 = 10'h007;
  localparam logic [9:0] IR_CLAMP                    = 10'h00A;
  localparam logic [9:0] IR_HIGHZ                    = 10'h00B;
  localparam logic [9:0] IR_CONFIG_IO                = 10'h00D;
  localparam logic [9:0] IR_ACTIVE_CONTROLLER_PARK   = 10'h2D0;
  localparam logic [9:0] IR_BYPASS                   = 10'h3FF;
  // shifts out as 1,0,1,0... starting at bit 0
  localparam logic [9:0] IR_CAPTURE_PATTERN          = 10'h155;

  // ----------------------------------------------------------------
  // identification register layout
  // ----------------------------------------------------------------
  localparam int          ID_W          = 32;
  localparam int          ID_VER_LSB    = 28;
  localparam int          ID_PART_LSB   = 12;
  localparam int          ID_MFR_LSB    = 1;
  localparam logic        ID_FIXED_LSB  = 1'b1;
  localparam logic [31:0] USERCODE_RST  = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // boundary cells, three per pin
  // ----------------------------------------------------------------
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_OUT      = 0;
  localparam int CELL_OE       = 1;
  localparam int CELL_IN       = 2;

  // ----------------------------------------------------------------
  // pin-steering and configuration-side mode bits handed to the core clock
  // ----------------------------------------------------------------
  localparam int MODE_W       = 5;
  localparam int MODE_EXTEST  = 0;
  localparam int MODE_CLAMP   = 1;
  localparam int MODE_HIGHZ   = 2;
  localparam int MODE_CFGIO   = 3;
  localparam int MODE_PARK    = 4;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
    TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } bsm_tap_state_t;

  typedef enum logic [2:0] {
    DR_BOUNDARY, DR_IDENT, DR_USER, DR_IOCFG, DR_BYPASS
  } bsm_dr_sel_t;

endpackage

/* File: src/bsm_scan.sv */
// boundary-scan data path: instruction decode, data registers, pin steering
`timescale 1ns/10ps

// How it works
// - sample capture loads pin, enable, data paths
// - sample keeps pins on functional data
// - shift chains cells from tdi to tdo
// - update copies capture cells into update cells
// - tap stays in shift while tms low
// - two tms highs from shift reach update
// - tdi bit crosses every cell before tdo
// - extest drives pins from update cells
// - enable cell one tri-states the pin
// - extest capture stores pin responses
// - all-ones instruction selects bypass
// - bypass takes tdi rising, shows falling
// - identification code loaded and shifted out
// - id: version, part, maker, fixed one
// - user code loaded into id register
// - user code default until configuration
// - clamp drives update cells, bypass path
// - configured keeper overrides clamp value
// - high-impedance tri-states all user pins
// - io config chain shifted and applied
// - config status low during io config
// - identification code instruction is 0x006
// - user code instruction is 0x007
// - test reset selects id, normal pins
// - tdo enabled only during shift states
module bsm_scan #(
  parameter int         NUM_PINS     = 8,
  parameter int         IOCFG_LEN    = 16,
  parameter logic [9:0] INSTR_SAMPLE = 10'h005,
  parameter logic [9:0] INSTR_EXTEST = 10'h000,
  // identity fields: arbitrary values
  parameter logic [3:0]  ID_VERSION  = 4'h1,
  parameter logic [15:0] ID_PART     = 16'h5A5A,
  parameter logic [10:0] ID_MFR      = 11'h0C3
) (
  // core clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // test access port
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdo_oe,
  // user io pins
  input  wire logic [NUM_PINS-1:0]  pin_in,
  output logic      [NUM_PINS-1:0]  pin_out,
  output logic      [NUM_PINS-1:0]  pin_oe,
  // functional core side
  input  wire logic [NUM_PINS-1:0]  func_out,
  input  wire logic [NUM_PINS-1:0]  func_oe,
  input  wire logic [NUM_PINS-1:0]  keeper_en,
  input  wire logic                 config_done,
  input  wire logic [31:0]          user_electronic_signature,
  // configuration side
  output logic                      config_status_pin_n,
  output logic                      config_status_pin_n_oe,
  output logic                      active_controller_park,
  output logic      [IOCFG_LEN-1:0] io_config_shift_chain
);

  localparam int BSR_W = bsm_pkg::CELLS_PER_PIN * NUM_PINS;

  if (NUM_PINS < 1 || IOCFG_LEN < 1 || INSTR_SAMPLE == INSTR_EXTEST ||
      INSTR_SAMPLE == bsm_pkg::IR_BYPASS || INSTR_EXTEST == bsm_pkg::IR_BYPASS)
  begin : g_chk
    $error("bsm_scan: unsupported pin count, chain length or instruction codes");
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic bsm_pkg::bsm_dr_sel_t dr_sel(input logic [9:0] ir);
    if (ir == INSTR_SAMPLE || ir == INSTR_EXTEST)
      return bsm_pkg::DR_BOUNDARY;
    else if (ir == bsm_pkg::IR_IDCODE)
      return bsm_pkg::DR_IDENT;
    else if (ir == bsm_pkg::IR_USERCODE)
      return bsm_pkg::DR_USER;
    else if (ir == bsm_pkg::IR_CONFIG_IO)
      return bsm_pkg::DR_IOCFG;
    else
      return bsm_pkg::DR_BYPASS;
  endfunction

  function automatic logic [bsm_pkg::MODE_W-1:0] mode_of(input logic [9:0] ir);
    logic [bsm_pkg::MODE_W-1:0] m;
    m = '0;
    m[bsm_pkg::MODE_EXTEST] = (ir == INSTR_EXTEST);
    m[bsm_pkg::MODE_CLAMP]  = (ir == bsm_pkg::IR_CLAMP);
    m[bsm_pkg::MODE_HIGHZ]  = (ir == bsm_pkg::IR_HIGHZ);
    m[bsm_pkg::MODE_CFGIO]  = (ir == bsm_pkg::IR_CONFIG_IO);
    m[bsm_pkg::MODE_PARK]   = (ir == bsm_pkg::IR_ACTIVE_CONTROLLER_PARK);
    return m;
  endfunction

  // ----------------------------------------------------------------
  // tap sequencer
  // ----------------------------------------------------------------
  bsm_pkg::bsm_tap_state_t state_r;

  bsm_tap u_tap (
    .tck     (tck),
    .rst_n   (rst_n),
    .tms     (tms),
    .state_r (state_r)
  );

  logic in_cap_dr;
  logic in_shift_dr;
  logic in_upd_dr;
  logic in_cap_ir;
  logic in_shift_ir;
  logic in_upd_ir;
  logic in_reset;

  assign in_cap_dr   = (state_r == bsm_pkg::TAP_CAP_DR);
  assign in_shift_dr = (state_r == bsm_pkg::TAP_SHIFT_DR);
  assign in_upd_dr   = (state_r == bsm_pkg::TAP_UPD_DR);
  assign in_cap_ir   = (state_r == bsm_pkg::TAP_CAP_IR);
  assign in_shift_ir = (state_r == bsm_pkg::TAP_SHIFT_IR);
  assign in_upd_ir   = (state_r == bsm_pkg::TAP_UPD_IR);
  assign in_reset    = (state_r == bsm_pkg::TAP_RESET);

  // ----------------------------------------------------------------
  // link-side copies of pin and core signals
  // ----------------------------------------------------------------
  // each bit is a snapshot of a wire, so bits need not be coherent with each other
  logic [3*NUM_PINS-1:0] pins_s;
  logic                  cfg_done_s;

  bsm_sync #(.WIDTH(3 * NUM_PINS)) u_sync_pins (
    .clk   (tck),
    .rst_n (rst_n),
    .d     ({pin_in, pin_oe, pin_out}),
    .q     (pins_s)
  );

  bsm_sync #(.WIDTH(1)) u_sync_cfg (
    .clk   (tck),
    .rst_n (rst_n),
    .d     (config_done),
    .q     (cfg_done_s)
  );

  logic [31:0] usercode_r;
  logic [31:0] user_word;

  // usercode_r only moves at the ref_clk edge that first sees config_done high, so it is settled once cfg_done_s is seen high
  assign user_word = cfg_done_s ? usercode_r : bsm_pkg::USERCODE_RST;

  logic [31:0] ident_word;

  assign ident_word = {ID_VERSION, ID_PART, ID_MFR, bsm_pkg::ID_FIXED_LSB};

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic [9:0] ir_sh_r;
  logic [9:0] ir_r;

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      ir_sh_r <= bsm_pkg::IR_CAPTURE_PATTERN;
    else if (in_cap_ir)
      ir_sh_r <= bsm_pkg::IR_CAPTURE_PATTERN;
    else if (in_shift_ir)
      ir_sh_r <= {tdi, ir_sh_r[9:1]};
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      ir_r <= bsm_pkg::IR_IDCODE;
    else if (in_reset)
      ir_r <= bsm_pkg::IR_IDCODE;
    else if (in_upd_ir)
      ir_r <= ir_sh_r;
  end

  bsm_pkg::bsm_dr_sel_t sel;

  assign sel = dr_sel(ir_r);

  // ----------------------------------------------------------------
  // boundary register: capture, shift and update cells
  // ----------------------------------------------------------------
  logic [BSR_W-1:0] bsr_r;
  logic [BSR_W-1:0] upd_r;

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      bsr_r <= '0;
    else if (sel == bsm_pkg::DR_BOUNDARY && in_cap_dr)
    begin
      // data path, enable path as tri-state flag, pin level
      for (int i = 0; i < NUM_PINS; i++)
      begin
        bsr_r[3*i+bsm_pkg::CELL_OUT] <= pins_s[i];
        bsr_r[3*i+bsm_pkg::CELL_OE]  <= ~pins_s[NUM_PINS+i];
        bsr_r[3*i+bsm_pkg::CELL_IN]  <= pins_s[2*NUM_PINS+i];
      end
    end
    else if (sel == bsm_pkg::DR_BOUNDARY && in_shift_dr)
      bsr_r <= {tdi, bsr_r[BSR_W-1:1]};
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      upd_r <= '0;
    else if (sel == bsm_pkg::DR_BOUNDARY && in_upd_dr)
      upd_r <= bsr_r;
  end

  // ----------------------------------------------------------------
  // identification, bypass and io config chains
  // ----------------------------------------------------------------
  logic [31:0]          id_r;
  logic                 byp_r;
  logic [IOCFG_LEN-1:0] iocfg_sh_r;
  logic [IOCFG_LEN-1:0] iocfg_r;

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      id_r <= '0;
    else if (in_cap_dr && sel == bsm_pkg::DR_IDENT)
      id_r <= ident_word;
    else if (in_cap_dr && sel == bsm_pkg::DR_USER)
      id_r <= user_word;
    else if (in_shift_dr && (sel == bsm_pkg::DR_IDENT || sel == bsm_pkg::DR_USER))
      id_r <= {tdi, id_r[31:1]};
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      byp_r <= 1'b0;
    else if (in_cap_dr && sel == bsm_pkg::DR_BYPASS)
      byp_r <= 1'b0;
    else if (in_shift_dr && sel == bsm_pkg::DR_BYPASS)
      byp_r <= tdi;
  end

  // capture reads back the applied settings before new ones go in
  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      iocfg_sh_r <= '0;
    else if (in_cap_dr && sel == bsm_pkg::DR_IOCFG)
      iocfg_sh_r <= iocfg_r;
    else if (in_shift_dr && sel == bsm_pkg::DR_IOCFG)
      iocfg_sh_r <= {tdi, iocfg_sh_r[IOCFG_LEN-1:1]};
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      iocfg_r <= '0;
    else if (in_upd_dr && sel == bsm_pkg::DR_IOCFG)
      iocfg_r <= iocfg_sh_r;
  end

  // ----------------------------------------------------------------
  // tdo on the falling edge
  // ----------------------------------------------------------------
  logic tdo_bit;

  always_comb
  begin
    tdo_bit = byp_r;
    if (in_shift_ir)
      tdo_bit = ir_sh_r[0];
    else
    begin
      case (sel)
        bsm_pkg::DR_BOUNDARY: tdo_bit = bsr_r[0];
        bsm_pkg::DR_IDENT:    tdo_bit = id_r[0];
        bsm_pkg::DR_USER:     tdo_bit = id_r[0];
        bsm_pkg::DR_IOCFG:    tdo_bit = iocfg_sh_r[0];
        default:              tdo_bit = byp_r;
      endcase
    end
  end

  always_ff @(negedge tck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo    <= tdo_bit;
      tdo_oe <= in_shift_ir || in_shift_dr;
    end
  end

  // ----------------------------------------------------------------
  // hand-off of instruction and update cells to the core clock
  // ----------------------------------------------------------------
  // request/acknowledge toggles; the held copy cannot change until the core has taken it
  logic                        pend_r;
  logic                        req_r;
  logic                        ack_s;
  logic                        launch;
  logic                        xfer_event;
  logic [bsm_pkg::MODE_W-1:0]  xfer_mode_r;
  logic [BSR_W-1:0]            xfer_upd_r;
  logic [IOCFG_LEN-1:0]        xfer_iocfg_r;

  assign xfer_event = in_upd_dr || in_upd_ir || (in_reset && ir_r != bsm_pkg::IR_IDCODE);
  assign launch     = pend_r && (req_r == ack_s);

  // a new event in the launch cycle keeps the request pending
  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      pend_r <= 1'b0;
    else
      pend_r <= xfer_event || (pend_r && !launch);
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_r        <= 1'b0;
      xfer_mode_r  <= '0;
      xfer_upd_r   <= '0;
      xfer_iocfg_r <= '0;
    end
    else if (launch)
    begin
      req_r        <= ~req_r;
      xfer_mode_r  <= mode_of(ir_r);
      xfer_upd_r   <= upd_r;
      xfer_iocfg_r <= iocfg_r;
    end
  end

  logic req_s;
  logic ack_r;

  bsm_sync #(.WIDTH(1)) u_sync_req (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (req_r),
    .q     (req_s)
  );

  bsm_sync #(.WIDTH(1)) u_sync_ack (
    .clk   (tck),
    .rst_n (rst_n),
    .d     (ack_r),
    .q     (ack_s)
  );

  logic [bsm_pkg::MODE_W-1:0] mode_r;
  logic [BSR_W-1:0]           upd_core_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r                 <= 1'b0;
      mode_r                <= '0;
      upd_core_r            <= '0;
      io_config_shift_chain <= '0;
    end
    else if (req_s != ack_r)
    begin
      ack_r                 <= req_s;
      mode_r                <= xfer_mode_r;
      upd_core_r            <= xfer_upd_r;
      io_config_shift_chain <= xfer_iocfg_r;
    end
  end

  // ----------------------------------------------------------------
  // user code capture in the core clock
  // ----------------------------------------------------------------
  logic cfg_done_d_r;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_done_d_r <= 1'b0;
    else
      cfg_done_d_r <= config_done;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      usercode_r <= bsm_pkg::USERCODE_RST;
    else if (config_done && !cfg_done_d_r)
      usercode_r <= user_electronic_signature;
  end

  // ----------------------------------------------------------------
  // pin steering
  // ----------------------------------------------------------------
  logic drive_upd;

  assign drive_upd = mode_r[bsm_pkg::MODE_EXTEST] || mode_r[bsm_pkg::MODE_CLAMP];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= '0;
      pin_oe  <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        if (mode_r[bsm_pkg::MODE_HIGHZ])
        begin
          pin_out[i] <= func_out[i];
          pin_oe[i]  <= 1'b0;
        end
        else if (drive_upd)
        begin
          pin_out[i] <= upd_core_r[3*i+bsm_pkg::CELL_OUT];
          // keeper must win over a clamped level once configured
          pin_oe[i]  <= ~upd_core_r[3*i+bsm_pkg::CELL_OE] &&
                        !(mode_r[bsm_pkg::MODE_CLAMP] && config_done && keeper_en[i]);
        end
        else
        begin
          pin_out[i] <= func_out[i];
          pin_oe[i]  <= func_oe[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration-side outputs
  // ----------------------------------------------------------------
  // open-drain status: only ever pulls low; the tester is expected to wait for it high first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_status_pin_n    <= 1'b0;
      config_status_pin_n_oe <= 1'b0;
      active_controller_park <= 1'b0;
    end
    else
    begin
      config_status_pin_n    <= 1'b0;
      config_status_pin_n_oe <= mode_r[bsm_pkg::MODE_CFGIO];
      active_controller_park <= mode_r[bsm_pkg::MODE_PARK];
    end
  end

endmodule

/* File: src/bsm_sync.sv */
// two-flop level synchroniser
`timescale 1ns/10ps
module bsm_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1)
  begin : g_chk
    $error("bsm_sync: WIDTH must be at least 1");
  end

  // meta_r feeds nothing but q
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* File: src/bsm_tap.sv */
// test access port state sequencer, clocked by tck
`timescale 1ns/10ps
module bsm_tap (
  // link clock and reset
  input  wire logic               tck,
  input  wire logic               rst_n,
  // mode select
  input  wire logic               tms,
  // current state
  output bsm_pkg::bsm_tap_state_t state_r
);

  bsm_pkg::bsm_tap_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      bsm_pkg::TAP_RESET:    state_nxt = tms ? bsm_pkg::TAP_RESET    : bsm_pkg::TAP_IDLE;
      bsm_pkg::TAP_IDLE:     state_nxt = tms ? bsm_pkg::TAP_SEL_DR   : bsm_pkg::TAP_IDLE;
      bsm_pkg::TAP_SEL_DR:   state_nxt = tms ? bsm_pkg::TAP_SEL_IR   : bsm_pkg::TAP_CAP_DR;
      bsm_pkg::TAP_CAP_DR:   state_nxt = tms ? bsm_pkg::TAP_EXIT1_DR : bsm_pkg::TAP_SHIFT_DR;
      bsm_pkg::TAP_SHIFT_DR: state_nxt = tms ? bsm_pkg::TAP_EXIT1_DR : bsm_pkg::TAP_SHIFT_DR;
      bsm_pkg::TAP_EXIT1_DR: state_nxt = tms ? bsm_pkg::TAP_UPD_DR   : bsm_pkg::TAP_PAUSE_DR;
      bsm_pkg::TAP_PAUSE_DR: state_nxt = tms ? bsm_pkg::TAP_EXIT2_DR : bsm_pkg::TAP_PAUSE_DR;
      bsm_pkg::TAP_EXIT2_DR: state_nxt = tms ? bsm_pkg::TAP_UPD_DR   : bsm_pkg::TAP_SHIFT_DR;
      bsm_pkg::TAP_UPD_DR:   state_nxt = tms ? bsm_pkg::TAP_SEL_DR   : bsm_pkg::TAP_IDLE;
      bsm_pkg::TAP_SEL_IR:   state_nxt = tms ? bsm_pkg::TAP_RESET    : bsm_pkg::TAP_CAP_IR;
      bsm_pkg::TAP_CAP_IR:   state_nxt = tms ? bsm_pkg::TAP_EXIT1_IR : bsm_pkg::TAP_SHIFT_IR;
      bsm_pkg::TAP_SHIFT_IR: state_nxt = tms ? bsm_pkg::TAP_EXIT1_IR : bsm_pkg::TAP_SHIFT_IR;
      bsm_pkg::TAP_EXIT1_IR: state_nxt = tms ? bsm_pkg::TAP_UPD_IR   : bsm_pkg::TAP_PAUSE_IR;
      bsm_pkg::TAP_PAUSE_IR: state_nxt = tms ? bsm_pkg::TAP_EXIT2_IR : bsm_pkg::TAP_PAUSE_IR;
      bsm_pkg::TAP_EXIT2_IR: state_nxt = tms ? bsm_pkg::TAP_UPD_IR   : bsm_pkg::TAP_SHIFT_IR;
      bsm_pkg::TAP_UPD_IR:   state_nxt = tms ? bsm_pkg::TAP_SEL_DR   : bsm_pkg::TAP_IDLE;
      default:               state_nxt = bsm_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= bsm_pkg::TAP_RESET;
    else
      state_r <= state_nxt;
  end

endmodule

/* File: verification/bsm_scan_properties.sv */
// port assertions of the boundary-scan data path
`timescale 1ns/10ps
module bsm_scan_chk #(
  parameter int NUM_PINS = 8
) (
  // clocks, reset, link
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic                tck,
  input wire logic                tms,
  input wire logic                tdo_oe,
  // pins and status
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] func_out,
  input wire logic                config_status_pin_n,
  input wire logic                config_status_pin_n_oe,
  input wire logic                active_controller_park
);
  // ----------------------------------------------------------------
  // tms as seen by the sequencer
  // ----------------------------------------------------------------
  logic tms_r;
  always_ff @(posedge tck or negedge rst_n)
  begin
    if (!rst_n)
      tms_r <= 1'b1;
    else
      tms_r <= tms;
  end
  // exit1 goes to pause or update, never back to shift
  sequence left_s;
    !tdo_oe ##1 !tdo_oe;
  endsequence
  AST_OE_RISE: assert property (@(negedge tck) disable iff (!rst_n) $rose(tdo_oe) |-> !$past(tms_r))
    else $error("tdo enable rose without tms low");
  AST_OE_FALL: assert property (@(negedge tck) disable iff (!rst_n) $fell(tdo_oe) |-> $past(tms_r))
    else $error("tdo enable fell without tms high");
  AST_SHIFT_HOLD: assert property (@(negedge tck) disable iff (!rst_n) tdo_oe && !tms_r |=> tdo_oe)
    else $error("shift left with tms low");
  AST_SHIFT_LEAVE: assert property (@(negedge tck) disable iff (!rst_n) tdo_oe && tms_r |=> left_s)
    else $error("shift kept after tms high");
  AST_STATUS_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n) config_status_pin_n_oe |-> !config_status_pin_n)
    else $error("status pin driven high");
  AST_ONE_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(config_status_pin_n_oe && active_controller_park))
    else $error("status pulled under another instruction");
  AST_RST_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> pin_oe == '0 && !config_status_pin_n_oe && !active_controller_park)
    else $error("outputs not quiet at reset release");
  AST_FUNC_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rst_n) $rose(rst_n) |-> ##2 pin_out == func_out)
    else $error("pins not functional after reset");
endmodule
bind bsm_scan bsm_scan_chk #(.NUM_PINS(NUM_PINS)) bsm_scan_chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck),
  .tms(tms), .tdo_oe(tdo_oe), .pin_out(pin_out), .pin_oe(pin_oe), .func_out(func_out),
  .config_status_pin_n(config_status_pin_n), .config_status_pin_n_oe(config_status_pin_n_oe),
  .active_controller_park(active_controller_park));

/* File: verification/bsm_scan_test.sv */
// self-checking bench of the boundary-scan data path
`timescale 1ns/10ps
module bsm_scan_test;
  // identity fields: arbitrary values
  localparam logic [31:0] ID_EXP = {4'h3, 16'h1234, 11'h055, 1'b1};
  localparam logic [9:0]  SAMPLE = 10'h005;
  localparam logic [9:0]  EXTEST = 10'h000;
  logic        ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, config_done, csn, csn_oe, park;
  logic [7:0]  pin_in, pin_out, pin_oe, func_out, func_oe, keeper_en;
  logic [31:0] sig, dout;
  logic [15:0] iocfg;
  int          errors, comparisons;
  // a released tdo reads inverted, so a late or missing enable shows up as a wrong bit
  bsm_tester tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe ? tdo : ~tdo));
  bsm_scan #(.INSTR_SAMPLE(SAMPLE), .INSTR_EXTEST(EXTEST), .ID_VERSION(ID_EXP[31:28]), .ID_PART(ID_EXP[27:12]),
    .ID_MFR(ID_EXP[11:1])) bsm_scan_i (.ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .func_out(func_out),
    .func_oe(func_oe), .keeper_en(keeper_en), .config_done(config_done), .user_electronic_signature(sig),
    .config_status_pin_n(csn), .config_status_pin_n_oe(csn_oe), .active_controller_park(park),
    .io_config_shift_chain(iocfg));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic settle;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic ir(input logic [9:0] code);
    tester_i.scan(1'b1, 10, {22'h0, code}, dout);
    compare(dout[9:0], bsm_pkg::IR_CAPTURE_PATTERN);
    settle;
  endtask
  // five tms highs reach test-logic-reset; the rest keep tck running for the hand-off
  task automatic tap_reset;
    logic o;
    repeat (16) tester_i.pulse(1'b1, 1'b0, o);
    settle;
  endtask
  // per pin: data path, enable cell, pin level
  function automatic logic [23:0] cells(input logic [7:0] d, input logic [7:0] t, input logic [7:0] p);
    for (int i = 0; i < 8; i++)
      cells[3*i+:3] = {p[i], t[i], d[i]};
  endfunction
  initial
  begin
    #100000;
    errors++;
    summarize;
  end
  initial
  begin
    {rst_n, config_done, sig, pin_in} = {2'b00, 32'h8E3B_61D4, 8'h96};
    {func_out, func_oe, keeper_en} = {8'h3C, 8'hF0, 8'h01};
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    settle;
    compare({pin_oe, pin_out}, {func_oe, func_out});
    tester_i.scan(1'b0, 32, 32'h0, dout);
    compare(dout, ID_EXP);
    ir(bsm_pkg::IR_USERCODE);
    tester_i.scan(1'b0, 32, 32'h0, dout);
    compare(dout, bsm_pkg::USERCODE_RST);
    @(negedge ref_clk) config_done = 1'b1;
    settle;
    tester_i.scan(1'b0, 32, 32'h0, dout);
    compare(dout, sig);
    ir(bsm_pkg::IR_BYPASS);
    tester_i.scan(1'b0, 8, 32'hA5, dout);
    compare(dout, 32'h4A);
    ir(SAMPLE);
    tester_i.scan(1'b0, 24, {8'h0, cells(8'h5A, 8'h08, 8'h00)}, dout);
    compare(dout[23:0], cells(func_out, ~func_oe, pin_in));
    settle;
    compare({pin_oe, pin_out}, {func_oe, func_out});
    ir(EXTEST);
    compare({pin_oe, pin_out}, 16'hF75A);
    pin_in = 8'h69;
    tester_i.scan(1'b0, 32, {cells(8'hC3, 8'h00, 8'h00), 8'hE4}, dout);
    compare(dout, {8'hE4, cells(8'h5A, 8'h08, 8'h69)});
    settle;
    compare({pin_oe, pin_out}, 16'hFFC3);
    ir(bsm_pkg::IR_CLAMP);
    compare({pin_oe, pin_out}, 16'hFEC3);
    tester_i.scan(1'b0, 2, 32'h3, dout);
    compare(dout, 32'h2);
    ir(bsm_pkg::IR_HIGHZ);
    compare(pin_oe, 8'h00);
    tap_reset;
    compare({pin_oe, pin_out}, {func_oe, func_out});
    tester_i.scan(1'b0, 32, 32'h0, dout);
    compare(dout, ID_EXP);
    ir(bsm_pkg::IR_ACTIVE_CONTROLLER_PARK);
    compare({park, csn_oe}, 2'b10);
    ir(bsm_pkg::IR_CONFIG_IO);
    compare({csn_oe, csn, park}, 3'b100);
    tester_i.scan(1'b0, 16, 32'hBEEF, dout);
    settle;
    compare(iocfg, 16'hBEEF);
    ir(bsm_pkg::IR_BYPASS);
    compare(csn_oe, 1'b0);
    summarize;
  end
endmodule

/* File: verification/bsm_tester.sv */
// external test controller model driving the test access port
`timescale 1ns/10ps
module bsm_tester (
  // test access port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one pulse; tck stands still between calls
  task automatic pulse(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #7.5 tck = 1'b1;
    o = tdo;
    #7.5 tck = 1'b0;
  endtask
  // scan from idle, lsb first, back to idle with room for the hand-off
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    pulse(1'b0, 1'b0, o);
    pulse(1'b1, 1'b0, o);
    if (ir)
      pulse(1'b1, 1'b0, o);
    pulse(1'b0, 1'b0, o);
    pulse(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], o);
      dout[i] = o;
    end
    pulse(1'b1, ~din[n-1], o);
    for (int i = 0; i < 14; i++)
      pulse(1'b0, ~din[n-1], o);
  endtask
endmodule
